// *** hdl/nps_map.vh ***
// Purpose: constants for the port status reporting block
// Assumes: 100 MHz mclk, word-wide register port with byte offsets
// Notes: every offset, field position, reset value and count lives here
`ifndef NPS_MAP_VH
`define NPS_MAP_VH

// register offsets on the plain register port
`define NPS_ADDR_W 8
`define NPS_OFF_STATUS 8'h00
`define NPS_OFF_CMD 8'h04
`define NPS_OFF_POLL 8'h08
`define NPS_OFF_MASK 8'h0C

// port status register reset value and fixed ones
`define NPS_STATUS_RST 32'h0039FF00
`define NPS_MBO_BITS 8'hFF

// port status register field positions
`define NPS_SUM_BIT 0
`define NPS_FLAG_LO 1
`define NPS_FLAG_HI 7
`define NPS_IRQ_SRC_LO 1
`define NPS_IRQ_SRC_HI 6
`define NPS_INIT_DONE_BIT 31
`define NPS_SELF_TEST_HI 30
`define NPS_SELF_TEST_LO 29
`define NPS_OP_MODE_HI 28
`define NPS_OP_MODE_LO 27
`define NPS_DMA_MODE_HI 26
`define NPS_DMA_MODE_LO 25
`define NPS_TX_STATE_HI 21
`define NPS_TX_STATE_LO 19
`define NPS_RX_STATE_HI 18
`define NPS_RX_STATE_LO 16

// flag positions inside the 7-bit flag vector (status bits 7:1)
`define NPS_FI_TX_DONE 0
`define NPS_FI_TX_WDOG 5
`define NPS_FI_MEM_ERR 3

// command and mode register fields and reset value, interrupt mask reset value
`define NPS_CMD_IE_BIT 30
`define NPS_CMD_ST_BIT 13
`define NPS_CMD_SR_BIT 12
`define NPS_CMD_RST 32'h00000000
`define NPS_MASK_RST 7'h3F

// transmit process state codes and the receive state reset code
`define NPS_TS_STOPPED 3'h7
`define NPS_TS_RUNNING 3'h1
`define NPS_TS_SUSPENDED 3'h3
`define NPS_RX_STATE_RST 3'h1

// gap between upper-half and lower-half update
`define NPS_CLK_NS 10
`define NPS_GAP_MAX_NS 40
`define NPS_GAP_MAX_CYC (`NPS_GAP_MAX_NS / `NPS_CLK_NS)
`define NPS_LOW_GAP_CYC 2

`endif

// *** hdl/nps_phase_seq.v ***
// Purpose: delays lower-half flag events behind the upper-half update
// Assumes: single mclk domain, synchronous active-high reset
// Notes: depth fixed at the low-half gap count, well under the maximum
`timescale 1ns/10ps
`include "nps_map.vh"

module nps_phase_seq (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire [6:0] evt_in,
    output wire [6:0] evt_out
);
    localparam DEPTH = `NPS_LOW_GAP_CYC;

    // stage k reads slice k of the chain and drives slice k+1
    wire [7*(DEPTH+1)-1:0] chain;

    assign chain[6:0] = evt_in;

    genvar i;
    // one register per cycle of gap; events only move while ce is high
    generate
        for (i = 0; i < DEPTH; i = i + 1) begin : g_stage
            reg [6:0] q;
            always @(posedge mclk) begin
                if (rst) begin
                    q <= 7'h00;
                end else if (ce) begin
                    q <= chain[7*i+6:7*i];
                end
            end
            assign chain[7*i+13:7*i+7] = q;
        end
    endgenerate

    // the last stage feeds the lower half
    assign evt_out = chain[7*DEPTH+6:7*DEPTH];
endmodule // nps_phase_seq

// *** hdl/nps_status.v ***
// Purpose: port status register, transmit process state and interrupt
// Assumes: all event inputs come from logic on mclk; no synchronisers
// Notes: upper half changes first, flags follow a fixed gap later;
// the gap is a fixed pipeline, so its worst case never depends on load
`timescale 1ns/10ps
`include "nps_map.vh"

module nps_status (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire tx_list_done,
    input wire tx_frame_abort,
    input wire tx_frame_done,
    input wire tx_desc_irq_on_complete,
    input wire tx_next_host_owned,
    input wire [5:0] flag_evt,
    input wire [2:0] rx_state_in,
    input wire stat_upd,
    input wire init_done_in,
    input wire [1:0] self_test_in,
    input wire [1:0] op_mode_in,
    input wire [1:0] dma_mode_in,
    output reg tx_run,
    output reg rx_start,
    output wire irq
);
    // transmit process states
    localparam TS_STOPPED = `NPS_TS_STOPPED;
    localparam TS_RUNNING = `NPS_TS_RUNNING;
    localparam TS_SUSPENDED = `NPS_TS_SUSPENDED;

    // positions of the transmit-stopping flags in the flag vector
    localparam FI_TX_WDOG = `NPS_FI_TX_WDOG;
    localparam FI_MEM_ERR = `NPS_FI_MEM_ERR;

    // register image, most significant first:
    //   31     init done
    //   30:29  self test result
    //   28:27  operating mode
    //   26:25  dma mode
    //   24:22  always zero
    //   21:19  transmit process state
    //   18:16  receive process state, copied from the receive engine
    //   15:8   read as ones, writes ignored
    //   7:1    sticky event flags, write one to clear
    //   0      summary of flags 6:1, never stored
    // the upper half is global state and changes first; the lower half
    // holds per-frame status and is the only part that can interrupt

    // lower half: sticky flags for status bits 7:1
    reg [6:0] flags;
    reg [6:0] next_flags;
    // upper half fields
    reg init_done_flag;
    reg [1:0] self_test_result_field;
    reg [1:0] operating_mode_field;
    reg [1:0] dma_mode_field;
    reg [2:0] tx_process_state;
    reg [2:0] next_tx_state;
    reg [2:0] rx_state;
    // command and mode register and interrupt mask
    reg [31:0] command_mode_register;
    reg [6:0] irq_mask;
    reg irq_out;
    reg [31:0] next_rdata;

    wire interrupt_enable_bit;
    wire start_transmit_cmd;
    wire start_receive_cmd;
    wire interrupt_summary_flag;
    wire [31:0] port_status_register;
    wire wr_status;
    wire wr_cmd;
    wire wr_poll;
    wire wr_mask;
    wire st_rise;
    wire st_fall;
    wire tx_done_evt;
    wire tx_suspend_evt;
    wire tx_stop_evt;
    wire [6:0] raw_evt;
    wire [6:0] low_evt;
    wire [6:0] clr_bits;
    wire tx_wdog_evt;
    wire mem_err_evt;
    wire [5:0] irq_src;
    wire [15:0] upper_half;
    wire [15:0] lower_half;

    // register port decode
    // full-width compare, so no register shows up at an alias address
    assign wr_status = reg_wr && (reg_addr == `NPS_OFF_STATUS);
    assign wr_cmd = reg_wr && (reg_addr == `NPS_OFF_CMD);
    assign wr_poll = reg_wr && (reg_addr == `NPS_OFF_POLL);
    assign wr_mask = reg_wr && (reg_addr == `NPS_OFF_MASK);

    // command register fields that steer this block
    assign interrupt_enable_bit = command_mode_register[`NPS_CMD_IE_BIT];
    assign start_transmit_cmd = command_mode_register[`NPS_CMD_ST_BIT];
    assign start_receive_cmd = command_mode_register[`NPS_CMD_SR_BIT];

    // host edges of the start-transmit bit, seen at the write itself
    // rewriting the same value is not an edge and moves nothing
    assign st_rise = wr_cmd && reg_wdata[`NPS_CMD_ST_BIT]
        && !start_transmit_cmd;
    assign st_fall = wr_cmd && !reg_wdata[`NPS_CMD_ST_BIT]
        && start_transmit_cmd;

    // transmit engine events that report through the done flag
    assign tx_done_evt = tx_list_done || tx_frame_abort
        || (tx_frame_done && tx_desc_irq_on_complete);
    // suspend unless the completion left the list still usable
    assign tx_suspend_evt = tx_list_done || tx_frame_abort
        || (tx_frame_done && tx_desc_irq_on_complete
        && tx_next_host_owned);
    // transmit watchdog: a babbling transmitter is cut off
    assign tx_wdog_evt = flag_evt[FI_TX_WDOG - 1];
    // memory error stops the transmit engine only; software must reinitialise
    assign mem_err_evt = flag_evt[FI_MEM_ERR - 1];
    // either one stops the transmitter outright, whatever its state
    assign tx_stop_evt = tx_wdog_evt || mem_err_evt;

    // every device-made state change carries a flag with it
    // index 0 is the transmit done flag; flag_evt fills bits 7:2
    assign raw_evt = {flag_evt, tx_done_evt};

    // transmit process state machine:
    //   stopped   -> running on a host start (no flag, host polls)
    //   running   -> suspended on list end, abort or host-owned stop
    //   running   -> stopped on host stop, watchdog or memory error
    //   suspended -> running on a poll demand write
    // device-made moves always travel with a flag through the gap stage
    always @* begin
        next_tx_state = tx_process_state;
        case (tx_process_state)
            TS_STOPPED: begin
                // host start: reported by polling, not by a flag
                if (st_rise) begin
                    next_tx_state = TS_RUNNING;
                end
            end
            TS_RUNNING: begin
                if (st_fall) begin
                    next_tx_state = TS_STOPPED;
                end else if (tx_stop_evt) begin
                    next_tx_state = TS_STOPPED;
                end else if (tx_suspend_evt) begin
                    next_tx_state = TS_SUSPENDED;
                end
            end
            TS_SUSPENDED: begin
                if (st_fall) begin
                    next_tx_state = TS_STOPPED;
                end else if (tx_stop_evt) begin
                    next_tx_state = TS_STOPPED;
                end else if (wr_poll) begin
                    // host poll demand restarts descriptor handling
                    next_tx_state = TS_RUNNING;
                end
            end
            default: begin
                // unused codes fall back to stopped
                next_tx_state = TS_STOPPED;
            end
        endcase
    end

    // upper half: state and host-commanded fields update at once
    // the receive state is a plain copy; its engine owns the codes
    always @(posedge mclk) begin
        if (rst) begin
            tx_process_state <= `NPS_TS_STOPPED;
            rx_state <= `NPS_RX_STATE_RST;
            init_done_flag <= 1'b0;
            self_test_result_field <= 2'h0;
            operating_mode_field <= 2'h0;
            dma_mode_field <= 2'h0;
        end else if (ce) begin
            tx_process_state <= next_tx_state;
            rx_state <= rx_state_in;
            // command acknowledges change status with no event
            if (stat_upd) begin
                init_done_flag <= init_done_in;
                self_test_result_field <= self_test_in;
                operating_mode_field <= op_mode_in;
                dma_mode_field <= dma_mode_in;
            end
        end
    end

    // events reach the lower half a fixed gap after the upper half
    nps_phase_seq u_phase (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .evt_in(raw_evt),
        .evt_out(low_evt)
    );

    // write-one-to-clear mask for bits 7:1; other bits ignore writes
    // clearing a bit that is already clear does nothing
    assign clr_bits = wr_status ? reg_wdata[`NPS_FLAG_HI:`NPS_FLAG_LO]
        : 7'h00;

    // a flag set in the same cycle as its clear is kept
    always @* begin
        next_flags = (flags & ~clr_bits) | low_evt;
    end

    // lower half flags
    // fed by the gap stage, so they always trail the upper half
    always @(posedge mclk) begin
        if (rst) begin
            flags <= 7'h00;
        end else if (ce) begin
            flags <= next_flags;
        end
    end

    // summary is pure logic so it can never disagree with the flags
    // bit 7 is left out on purpose: it is sticky status only
    assign interrupt_summary_flag =
        |flags[`NPS_IRQ_SRC_HI - 1:`NPS_IRQ_SRC_LO - 1];

    // upper half: global state, host-commanded fields and process states
    assign upper_half = {
        init_done_flag,
        self_test_result_field,
        operating_mode_field,
        dma_mode_field,
        3'h0,
        tx_process_state,
        rx_state
    };
    // lower half: fixed ones, sticky flags and their summary
    assign lower_half = {
        `NPS_MBO_BITS,
        flags,
        interrupt_summary_flag
    };

    // full register image as the host sees it
    assign port_status_register = {upper_half, lower_half};

    // command register and mask; reset keeps interrupts disabled
    // every command bit is stored, only three of them steer this block
    always @(posedge mclk) begin
        if (rst) begin
            command_mode_register <= `NPS_CMD_RST;
            irq_mask <= `NPS_MASK_RST;
        end else if (ce) begin
            if (wr_cmd) begin
                command_mode_register <= reg_wdata;
            end
            if (wr_mask) begin
                irq_mask <= reg_wdata[`NPS_FLAG_HI:`NPS_FLAG_LO];
            end
        end
    end

    // control outputs to the transmit and receive engines; tx_run uses
    // the next state so the engine stops in the cycle the state does
    always @(posedge mclk) begin
        if (rst) begin
            tx_run <= 1'b0;
            rx_start <= 1'b0;
        end else if (ce) begin
            tx_run <= (next_tx_state == TS_RUNNING);
            rx_start <= start_receive_cmd;
        end
    end

    // enabled sources among bits 6:1, taken from the next flag value;
    // this lets the output move in the same cycle as the flag it follows,
    // at the cost of a longer path from the event stage to the output
    assign irq_src = next_flags[5:0] & irq_mask[5:0];

    // interrupt is level: held while an enabled source flag remains;
    // bit 7 is sticky but never interrupts, as it lies outside 6:1
    always @(posedge mclk) begin
        if (rst) begin
            irq_out <= 1'b0;
        end else if (ce) begin
            irq_out <= interrupt_enable_bit && |irq_src;
        end
    end

    assign irq = irq_out;

    // read mux; poll demand and unmapped addresses read zero
    always @* begin
        next_rdata = 32'h00000000;
        if (reg_rd) begin
            case (reg_addr)
                `NPS_OFF_STATUS: begin
                    next_rdata = port_status_register;
                end
                `NPS_OFF_CMD: begin
                    next_rdata = command_mode_register;
                end
                `NPS_OFF_MASK: begin
                    next_rdata = {24'h000000, irq_mask, 1'b0};
                end
                default: begin
                    next_rdata = 32'h00000000;
                end
            endcase
        end
    end

    // read port: data stand the cycle after the strobe, only then;
    // the zero between reads keeps stale status off the bus
    always @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (ce) begin
            reg_rdata <= next_rdata;
        end
    end
endmodule // nps_status

// *** verification/nps_host.sv ***
// Purpose: host driver model on the register port
// Assumes: strobes change just after a rising edge
// Notes: write data is scrambled once released, so nothing lingers
`timescale 1ns/10ps
`include "nps_map.vh"
module nps_host (
    input wire logic mclk,
    input wire logic [31:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    // one-cycle write strobe
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
    endtask
    // read data stands only in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // command acknowledge is only visible by polling, bounded tries
    task poll(input logic [31:0] m, e, output logic [31:0] v);
        for (int i = 0; i < 8; i++) begin
            rd(`NPS_OFF_STATUS, v);
            if ((v & m) === e) break;
        end
    endtask
    // one word read gives cause and state, then clear what was seen
    task isr(output logic [31:0] v);
        rd(`NPS_OFF_STATUS, v);
        wr(`NPS_OFF_STATUS, v);
    endtask
    // resume a suspended transmit
    task demand;
        wr(`NPS_OFF_POLL, 32'h0);
    endtask
endmodule // nps_host

// *** verification/nps_status_asserts.sv ***
// Purpose: port-level checks of status flags and interrupt
// Assumes: ce held high; single mclk domain
// Notes: shadows enable and mask bit 1 to judge irq
`timescale 1ns/10ps
`include "nps_map.vh"
module nps_status_asserts (
    input wire mclk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire tx_list_done,
    input wire tx_frame_abort,
    input wire tx_frame_done,
    input wire tx_desc_irq_on_complete,
    input wire tx_next_host_owned,
    input wire stat_upd,
    input wire tx_run,
    input wire irq
);
    logic ie;
    logic m1;
    logic wcmd;
    assign wcmd = reg_wr && reg_addr == `NPS_OFF_CMD;
    // shadow of the enable bit and mask bit 1 written by the host
    always_ff @(posedge mclk) begin
        if (rst) begin
            ie <= 1'b0;
            m1 <= 1'b1;
        end else begin
            if (wcmd) ie <= reg_wdata[30];
            if (reg_wr && reg_addr == `NPS_OFF_MASK) m1 <= reg_wdata[1];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    list_suspend_a: assert property (tx_list_done |=> !tx_run)
        else $error("transmit runs after list end");
    abort_stop_a: assert property (tx_frame_abort |=> !tx_run)
        else $error("transmit runs after abort");
    ic_keep_a: assert property (tx_frame_done && tx_desc_irq_on_complete
        && !tx_next_host_owned && tx_run |=> tx_run)
        else $error("completion stopped transmit");
    tx_irq_a: assert property (tx_list_done && ie && m1 |-> ##[2:4] irq)
        else $error("interrupt late after list end");
    upper_first_a: assert property (tx_list_done && !irq |=> !irq [*2])
        else $error("interrupt before upper half");
    cmd_quiet_a: assert property (wcmd && !reg_wdata[30] && !irq
        |=> !irq [*4])
        else $error("command raised interrupt");
    stat_quiet_a: assert property (stat_upd && !irq |=> !irq [*4])
        else $error("status update raised interrupt");
    clr_drop_a: assert property (reg_wr && reg_addr == `NPS_OFF_STATUS
        && &reg_wdata[6:1] |=> !irq)
        else $error("interrupt held after clear");
    ie_gate_a: assert property (!ie && !$past(ie) |-> !irq)
        else $error("interrupt while disabled");
    sum_or_a: assert property ($past(reg_rd)
        && $past(reg_addr) == `NPS_OFF_STATUS
        |-> reg_rdata[0] == |reg_rdata[6:1])
        else $error("summary bit wrong");
    cover property ($rose(irq));
    cover property (tx_frame_done && tx_desc_irq_on_complete);
    cover property (stat_upd);
endmodule // nps_status_asserts

// *** verification/nps_status_test.sv ***
// Purpose: self-checking bench for the port status reporting block
// Assumes: ce tied high; receive state set by the bench (t_stat); host model drives the port
// Notes: irq is checked five cycles after its event, the flags by a status read two cycles after that
`timescale 1ns/10ps
`include "nps_map.vh"
module nps_status_test;
    logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, stat_upd = 1'b0;
    logic tx_list_done = 1'b0, tx_frame_abort = 1'b0, tx_frame_done = 1'b0;
    logic tx_desc_irq_on_complete = 1'b0, tx_next_host_owned = 1'b0;
    logic [5:0] flag_evt = 6'h00;
    logic [2:0] rx_state_in = `NPS_RX_STATE_RST;
    logic init_done_in = 1'b0;
    logic [1:0] self_test_in = 2'h0, op_mode_in = 2'h0, dma_mode_in = 2'h0;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, tx_run, rx_start, irq;
    int err_total = 0, n_checks = 0;
    nps_status DUT (.mclk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .tx_list_done, .tx_frame_abort, .tx_frame_done,
        .tx_desc_irq_on_complete, .tx_next_host_owned, .flag_evt,
        .rx_state_in, .stat_upd, .init_done_in, .self_test_in, .op_mode_in,
        .dma_mode_in, .tx_run, .rx_start, .irq);
    nps_host h (.mclk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
    initial forever #5 mclk = ~mclk;
    task chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s exp %h seen %h", nm, e, s);
        end
    endtask
    task finish_test;
        if (err_total == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one-cycle event pulse, then let the lower half land
    task ev(input int k, input logic [5:0] f);
        @(posedge mclk);
        case (k)
            0: tx_list_done <= 1'b1;
            1: tx_frame_abort <= 1'b1;
            2: tx_frame_done <= 1'b1;
            3: stat_upd <= 1'b1;
            default: flag_evt <= f;
        endcase
        @(posedge mclk);
        {tx_list_done, tx_frame_abort, tx_frame_done, stat_upd} <= 4'h0;
        flag_evt <= 6'h00;
        repeat (5) @(posedge mclk);
    endtask
    // event, check irq, then service; flag byte and transmit state come from its read, then irq must clear
    task evchk(input int k, input logic [5:0] f, input logic [7:0] lo,
        input logic [2:0] ts, input logic q);
        ev(k, f);
        chk("irq", irq, q);
        h.isr(d);
        chk("flags", d[7:0], lo);
        chk("tx state", d[21:19], ts);
        @(posedge mclk);
        chk("irq clear", irq, 1'b0);
    endtask
    task t_reset;
        h.rd(`NPS_OFF_STATUS, d);
        chk("status reset", d, `NPS_STATUS_RST);
        h.rd(`NPS_OFF_MASK, d);
        chk("mask reset", d, 32'h7E);
        h.rd(8'hF0, d);
        chk("unmapped", d, 32'h0);
    endtask
    task t_start;
        h.wr(`NPS_OFF_CMD, 32'h0000_3000);
        h.poll(32'h0038_0000, 32'h0008_0000, d);
        chk("start ack", d[21:19], `NPS_TS_RUNNING);
        chk("start flags", d[7:0], 8'h00);
        chk("rx start", rx_start, 1'b1);
        h.wr(`NPS_OFF_CMD, 32'h0000_1000);
        h.poll(32'h0038_0000, 32'h0038_0000, d);
        chk("stop ack", d[21:19], `NPS_TS_STOPPED);
        chk("stop flags", d[7:0], 8'h00);
        h.wr(`NPS_OFF_CMD, 32'h4000_3000);
    endtask
    task t_list;
        ev(0, 6'h00);
        h.wr(`NPS_OFF_STATUS, 32'h0);
        h.rd(`NPS_OFF_STATUS, d);
        chk("zero write", d[7:0], 8'h03);
        h.wr(`NPS_OFF_STATUS, 32'hFFFF_FFFF);
        h.rd(`NPS_OFF_STATUS, d);
        chk("w1c word", d, 32'h0019_FF00);
        h.demand;
        h.rd(`NPS_OFF_STATUS, d);
        chk("resume", d[21:19], `NPS_TS_RUNNING);
    endtask
    task t_tx;
        tx_desc_irq_on_complete <= 1'b1;
        evchk(2, 6'h00, 8'h03, `NPS_TS_RUNNING, 1'b1);
        tx_next_host_owned <= 1'b1;
        evchk(2, 6'h00, 8'h03, `NPS_TS_SUSPENDED, 1'b1);
        h.demand;
        evchk(1, 6'h00, 8'h03, `NPS_TS_SUSPENDED, 1'b1);
        h.demand;
        evchk(0, 6'h00, 8'h03, `NPS_TS_SUSPENDED, 1'b1);
        h.wr(`NPS_OFF_MASK, 32'h0);
        h.demand;
        evchk(0, 6'h00, 8'h03, `NPS_TS_SUSPENDED, 1'b0);
        h.wr(`NPS_OFF_MASK, 32'h7E);
        h.wr(`NPS_OFF_CMD, 32'h0000_3000);
        h.demand;
        evchk(0, 6'h00, 8'h03, `NPS_TS_SUSPENDED, 1'b0);
        h.wr(`NPS_OFF_CMD, 32'h4000_3000);
        h.demand;
        evchk(4, 6'h20, 8'h80, `NPS_TS_RUNNING, 1'b0);
        evchk(4, 6'h04, 8'h11, `NPS_TS_STOPPED, 1'b1);
    endtask
    task t_stat;
        {init_done_in, self_test_in, op_mode_in, dma_mode_in} <= 7'h4F;
        rx_state_in <= 3'h3;
        ev(3, 6'h00);
        h.rd(`NPS_OFF_STATUS, d);
        chk("upper fields", d[31:25], 7'h4F);
        chk("stat flags", d[7:0], 8'h00);
        chk("rx state", d[18:16], 3'h3);
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_reset;
        t_start;
        t_list;
        t_tx;
        t_stat;
        finish_test;
    end
    initial begin
        #100000;
        err_total++;
        finish_test;
    end
endmodule // nps_status_test
bind nps_status nps_status_asserts u_chk (.mclk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_list_done, .tx_frame_abort,
    .tx_frame_done, .tx_desc_irq_on_complete, .tx_next_host_owned,
    .stat_upd, .tx_run, .irq);
